// [hdl/sbt_tap.sv]
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns

module sbt_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
      $error("sbt_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   logic             push;
   logic             pop;

   assign in_ready  = !((wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
   assign out_valid = (wr_ptr_r != rd_ptr_r);
   assign out_data  = mem[rd_ptr_r[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge pclk) begin
      if (push) begin
         mem[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule : sbt_fifo

module sbt_tap
   import sbt_pkg::*;
#(
   parameter int          FIFO_DEPTH = `SBT_FIFO_DEPTH,
   parameter logic [3:0]  ID_REVISION = 4'h1,
   parameter logic [15:0] ID_PART     = 16'h0123,
   parameter logic [10:0] ID_VENDOR   = 11'h055
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire sbt_pins_type tap_in,
   output logic              tdo,
   output logic              tdo_oe,
   input  wire sbt_ring_type io_ring
);
   // ID_REVISION, ID_PART and ID_VENDOR defaults are arbitrary values

   if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("sbt_tap: FIFO_DEPTH too small");
   end

   localparam logic [`SBT_ID_W-1:0] ID_VALUE = {ID_REVISION, ID_PART, ID_VENDOR, 1'b1};

   function automatic logic [1:0] reg_sel(input logic [11:0] addr);
      case (addr)
         `SBT_OFF_CTRL:   reg_sel = 2'h1;
         `SBT_OFF_STATUS: reg_sel = 2'h2;
         `SBT_OFF_DATA:   reg_sel = 2'h3;
         default:         reg_sel = 2'h0;
      endcase
   endfunction : reg_sel

   function automatic sbt_tap_state_type tap_next(input sbt_tap_state_type s, input logic m);
      case (s)
         SBT_TLR:   tap_next = m ? SBT_TLR   : SBT_RTI;
         SBT_RTI:   tap_next = m ? SBT_SELDR : SBT_RTI;
         SBT_SELDR: tap_next = m ? SBT_SELIR : SBT_CAPDR;
         SBT_CAPDR: tap_next = m ? SBT_EX1DR : SBT_SHDR;
         SBT_SHDR:  tap_next = m ? SBT_EX1DR : SBT_SHDR;
         SBT_EX1DR: tap_next = m ? SBT_UPDR  : SBT_PSDR;
         SBT_PSDR:  tap_next = m ? SBT_EX2DR : SBT_PSDR;
         SBT_EX2DR: tap_next = m ? SBT_UPDR  : SBT_SHDR;
         SBT_UPDR:  tap_next = m ? SBT_SELDR : SBT_RTI;
         SBT_SELIR: tap_next = m ? SBT_TLR   : SBT_CAPIR;
         SBT_CAPIR: tap_next = m ? SBT_EX1IR : SBT_SHIR;
         SBT_SHIR:  tap_next = m ? SBT_EX1IR : SBT_SHIR;
         SBT_EX1IR: tap_next = m ? SBT_UPIR  : SBT_PSIR;
         SBT_PSIR:  tap_next = m ? SBT_EX2IR : SBT_PSIR;
         SBT_EX2IR: tap_next = m ? SBT_UPIR  : SBT_SHIR;
         SBT_UPIR:  tap_next = m ? SBT_SELDR : SBT_RTI;
         default:   tap_next = SBT_TLR;
      endcase
   endfunction : tap_next

   // Pin synchronisers
   sbt_pins_type pins_s1_r;
   sbt_pins_type pins_s2_r;
   logic         tck_prev_r;
   logic         tck_rise;
   logic         tck_fall;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_s1_r  <= '0;
         pins_s2_r  <= '0;
         tck_prev_r <= 1'b0;
      end else begin
         pins_s1_r  <= tap_in;
         pins_s2_r  <= pins_s1_r;
         tck_prev_r <= pins_s2_r.tck;
      end
   end

   assign tck_rise = pins_s2_r.tck && !tck_prev_r;
   assign tck_fall = !pins_s2_r.tck && tck_prev_r;

   // TAP state machine
   sbt_tap_state_type state_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= SBT_TLR;
      end else if (tck_rise) begin
         state_r <= tap_next(state_r, pins_s2_r.tms);
      end
   end

   // Instruction register
   sbt_instr_type ir_shift_r;
   sbt_instr_type ir_r;
   logic          sel_id;
   logic          sel_bnd;
   logic          sel_byp;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir_shift_r <= `SBT_IR_CAPTURE;
         ir_r       <= `SBT_IR_IDCODE;
      end else if (tck_rise) begin
         case (state_r)
            SBT_TLR:   ir_r       <= `SBT_IR_IDCODE;
            SBT_CAPIR: ir_shift_r <= `SBT_IR_CAPTURE;
            SBT_SHIR:  ir_shift_r <= {pins_s2_r.tdi, ir_shift_r[`SBT_IR_W-1:1]};
            SBT_UPIR:  ir_r       <= ir_shift_r;
            default:   ir_r       <= ir_r;
         endcase
      end
   end

   assign sel_id  = (ir_r == `SBT_IR_IDCODE);
   assign sel_bnd = (ir_r == `SBT_IR_EXTEST) || (ir_r == `SBT_IR_SAMPLE);
   assign sel_byp = !sel_id && !sel_bnd;

   // Data registers
   logic                  byp_r;
   logic [`SBT_ID_W-1:0]  id_r;
   logic [`SBT_BND_W-1:0] bnd_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byp_r <= `SBT_BYP_CAPTURE;
         id_r  <= '0;
         bnd_r <= '0;
      end else if (tck_rise) begin
         if (state_r == SBT_CAPDR) begin
            if (sel_byp) begin
               byp_r <= `SBT_BYP_CAPTURE;
            end
            if (sel_id) begin
               id_r <= ID_VALUE;
            end
            if (sel_bnd) begin
               bnd_r <= io_ring;
            end
         end else if (state_r == SBT_SHDR) begin
            if (sel_byp) begin
               byp_r <= pins_s2_r.tdi;
            end
            if (sel_id) begin
               id_r <= {pins_s2_r.tdi, id_r[`SBT_ID_W-1:1]};
            end
            if (sel_bnd) begin
               bnd_r <= {pins_s2_r.tdi, bnd_r[`SBT_BND_W-1:1]};
            end
         end
      end
   end

   // Serial output, changes on falling test clock
   logic tdo_r;
   logic tdo_oe_r;
   logic dr_out;

   assign dr_out = sel_id ? id_r[0] : (sel_bnd ? bnd_r[0] : byp_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tdo_r    <= 1'b0;
         tdo_oe_r <= 1'b0;
      end else if (tck_fall) begin
         tdo_r    <= (state_r == SBT_SHIR) ? ir_shift_r[0] : dr_out;
         tdo_oe_r <= (state_r == SBT_SHIR) || (state_r == SBT_SHDR);
      end
   end

   assign tdo    = tdo_r;
   assign tdo_oe = tdo_oe_r;

   // Collector of shifted-in data words
   logic                   collect_r;
   logic [`SBT_WORD_W-1:0] word_r;
   logic [4:0]             bits_r;
   logic                   pend_r;
   logic [`SBT_WORD_W-1:0] pend_word_r;
   logic                   ovf_r;
   logic                   fifo_in_ready;
   logic [`SBT_WORD_W-1:0] fifo_out_data;
   logic                   fifo_out_valid;
   logic                   fifo_pop;
   logic                   word_done;
   logic                   ovf_clr;

   assign word_done = tck_rise && collect_r && (state_r == SBT_SHDR) && (bits_r == 5'h1f);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_r <= '0;
         bits_r <= '0;
      end else if (tck_rise && collect_r && (state_r == SBT_SHDR)) begin
         word_r <= {pins_s2_r.tdi, word_r[`SBT_WORD_W-1:1]};
         bits_r <= bits_r + 5'h01;
      end
   end

   // Shifting goes on while the FIFO is full, so the word waits in its own slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r      <= 1'b0;
         pend_word_r <= '0;
      end else if (word_done) begin
         pend_r <= 1'b1;
         if (!pend_r || fifo_in_ready) begin
            pend_word_r <= {pins_s2_r.tdi, word_r[`SBT_WORD_W-1:1]};
         end
      end else if (fifo_in_ready) begin
         pend_r <= 1'b0;
      end
   end

   // Overflow: set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_r <= 1'b0;
      end else if (word_done && pend_r && !fifo_in_ready) begin
         ovf_r <= 1'b1;
      end else if (ovf_clr) begin
         ovf_r <= 1'b0;
      end
   end

   sbt_fifo #(
      .WIDTH (`SBT_WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_data   (pend_word_r),
      .in_valid  (pend_r),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop)
   );

   // APB slave, zero wait states
   logic        setup;
   logic        access;
   logic [1:0]  sel;
   logic [31:0] prdata_r;
   logic        pslverr_r;
   logic [31:0] status;

   assign setup  = psel && !penable;
   assign access = psel && penable;
   assign sel    = reg_sel(paddr);

   always_comb begin
      status = '0;
      status[`SBT_ST_STATE_LO +: 4]        = state_r;
      status[`SBT_ST_INSTR_LO +: `SBT_IR_W] = ir_r;
      status[`SBT_ST_NEMPTY]               = fifo_out_valid;
      status[`SBT_ST_OVF]                  = ovf_r;
      status[`SBT_ST_PEND]                 = pend_r;
   end

   assign fifo_pop = access && !pwrite && (sel == 2'h3) && fifo_out_valid;
   assign ovf_clr  = access && pwrite && (sel == 2'h2) && pwdata[`SBT_ST_OVF];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         collect_r <= `SBT_CTRL_RST;
      end else if (access && pwrite && (sel == 2'h1)) begin
         collect_r <= pwdata[`SBT_CTRL_COLLECT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= '0;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         pslverr_r <= (sel == 2'h0) || (pwrite && (sel == 2'h3));
         case (sel)
            2'h1:    prdata_r <= {31'h0, collect_r};
            2'h2:    prdata_r <= status;
            2'h3:    prdata_r <= fifo_out_valid ? fifo_out_data : 32'h0;
            default: prdata_r <= 32'h0;
         endcase
      end
   end

   assign prdata  = prdata_r;
   assign pready  = 1'b1;
   assign pslverr = pslverr_r && access;
endmodule : sbt_tap

// [common/sbt_cfg.svh]
`ifndef SBT_CFG_SVH
`define SBT_CFG_SVH

// Register offsets
`define SBT_OFF_CTRL     12'h000
`define SBT_OFF_STATUS   12'h004
`define SBT_OFF_DATA     12'h008

// Control fields
`define SBT_CTRL_COLLECT 0
`define SBT_CTRL_RST     1'h0

// Status fields
`define SBT_ST_STATE_LO  0
`define SBT_ST_INSTR_LO  4
`define SBT_ST_NEMPTY    8
`define SBT_ST_OVF       9
`define SBT_ST_PEND      10

// Instruction codes
`define SBT_IR_EXTEST    3'h0
`define SBT_IR_IDCODE    3'h1
`define SBT_IR_SAMPLE    3'h2
`define SBT_IR_BYPASS    3'h7
`define SBT_IR_CAPTURE   3'h1

// Widths and reset values
`define SBT_IR_W         3
`define SBT_ID_W         32
`define SBT_BND_W        109
`define SBT_WORD_W       32
`define SBT_FIFO_DEPTH   16
`define SBT_BYP_CAPTURE  1'h0

`endif

// [common/sbt_pkg.sv]
`include "sbt_cfg.svh"

package sbt_pkg;

   typedef enum logic [3:0] {
      SBT_TLR   = 4'hf,
      SBT_RTI   = 4'hc,
      SBT_SELDR = 4'h7,
      SBT_CAPDR = 4'h6,
      SBT_SHDR  = 4'h2,
      SBT_EX1DR = 4'h1,
      SBT_PSDR  = 4'h3,
      SBT_EX2DR = 4'h0,
      SBT_UPDR  = 4'h5,
      SBT_SELIR = 4'h4,
      SBT_CAPIR = 4'he,
      SBT_SHIR  = 4'ha,
      SBT_EX1IR = 4'h9,
      SBT_PSIR  = 4'hb,
      SBT_EX2IR = 4'h8,
      SBT_UPIR  = 4'hd
   } sbt_tap_state_type;

   typedef logic [`SBT_IR_W-1:0] sbt_instr_type;

   // Boundary ring, lowest bit leaves first
   typedef struct packed {
      logic [98:0] rest;
      logic        data_low;
      logic [6:0]  address_in;
      logic        read_data_valid_output;
      logic        termination_control_input;
   } sbt_ring_type;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } sbt_pins_type;

endpackage : sbt_pkg

// [bench/sbt_tap_monitor.sv]
`timescale 1ns/1ns
`include "sbt_cfg.svh"
module sbt_tap_monitor
   import sbt_pkg::*;
(
   input wire logic         pclk,
   input wire logic         presetn,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [11:0]  paddr,
   input wire logic [31:0]  prdata,
   input wire logic         pready,
   input wire logic         pslverr,
   input wire sbt_pins_type tap_in,
   input wire logic         tdo,
   input wire logic         tdo_oe
);
   logic       tck_q_r;
   logic [2:0] hi_cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tck_q_r <= 1'h0;
      end else begin
         tck_q_r <= tap_in.tck;
      end
   end
   // Consecutive rises of the test clock with mode select high, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_cnt_r <= 3'h0;
      end else if (tap_in.tck && !tck_q_r) begin
         hi_cnt_r <= !tap_in.tms ? 3'h0 : (hi_cnt_r == 3'h7 ? hi_cnt_r : hi_cnt_r + 3'h1);
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_high_a: assert property (psel |-> pready) else $error("pready low");
   err_access_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
   unmapped_err_a: assert property (psel && penable && paddr > `SBT_OFF_DATA |-> pslverr)
      else $error("unmapped access without error");
   data_write_a: assert property (psel && penable && pwrite && paddr == `SBT_OFF_DATA |-> pslverr)
      else $error("data write without error");
   err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error read not zero");
   tdo_fall_a: assert property ($changed(tdo) |-> !$past(tap_in.tck))
      else $error("tdo moved while clock high");
   oe_fall_a: assert property ($changed(tdo_oe) |-> !$past(tap_in.tck))
      else $error("tdo_oe moved while clock high");
   shift_exit_a: assert property (hi_cnt_r >= 3'h3 |-> !tdo_oe)
      else $error("driving after mode select high");
endmodule : sbt_tap_monitor

bind sbt_tap sbt_tap_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .tap_in(tap_in), .tdo(tdo), .tdo_oe(tdo_oe));

// [bench/sbt_jtag_ctl.sv]
`timescale 1ns/1ns
module sbt_jtag_ctl
   import sbt_pkg::*;
(
   output sbt_pins_type pins,
   input  wire logic    tdo
);
   initial pins = '0;
   // One clock period; clock stands low between frames
   task automatic tick(input logic ms, input logic di, output logic so);
      pins.tms = ms;
      pins.tdi = di;
      #16 pins.tck = 1'h1;
      so = tdo;
      #16 pins.tck = 1'h0;
   endtask : tick
   task automatic enter(input logic ir);
      logic so;
      #1;
      tick(1'h1, ~pins.tdi, so);
      if (ir) tick(1'h1, ~pins.tdi, so);
      tick(1'h0, ~pins.tdi, so);
      tick(1'h0, ~pins.tdi, so);
   endtask : enter
   task automatic reset5();
      logic so;
      #1;
      repeat (5) tick(1'h1, ~pins.tdi, so);
      tick(1'h0, ~pins.tdi, so);
   endtask : reset5
   task automatic scan(input logic ir, input int n, input logic [108:0] din, output logic [108:0] dout);
      logic so;
      dout = '0;
      enter(ir);
      for (int k = 0; k < n; k++) begin
         tick(k == n - 1, din[k], so);
         dout[k] = so;
      end
      tick(1'h1, ~pins.tdi, so);
      tick(1'h0, ~pins.tdi, so);
   endtask : scan
endmodule : sbt_jtag_ctl

// [bench/sbt_tap_tb.sv]
`timescale 1ns/1ns
`include "sbt_cfg.svh"
module sbt_tap_tb
   import sbt_pkg::*;
;
   // Arbitrary identity values
   localparam logic [3:0]  REV  = 4'h6;
   localparam logic [15:0] PART = 16'h0a5c;
   localparam logic [10:0] VEND = 11'h2b3;
   logic         pclk = 1'h0;
   logic         presetn = 1'h0;
   logic         psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0]  paddr = 12'h0;
   logic [31:0]  pwdata = 32'h0, prdata, rd;
   logic         pready, pslverr, tdo, tdo_oe, err;
   sbt_pins_type tap_in;
   sbt_ring_type io_ring = '0;
   logic [108:0] din, dout;
   logic [31:0]  q[$];
   int           seed = 32'h6486;
   int           mismatches = 0, tests_run = 0, i;
   always #2 pclk = ~pclk;
   sbt_tap #(.ID_REVISION(REV), .ID_PART(PART), .ID_VENDOR(VEND)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tap_in(tap_in), .tdo(tdo), .tdo_oe(tdo_oe), .io_ring(io_ring));
   sbt_jtag_ctl ctl (.pins(tap_in), .tdo(tdo));
   function automatic logic [31:0] id_exp();
      return {REV, PART, VEND, 1'h1};
   endfunction : id_exp
   function automatic logic [7:0] byp_exp(input logic [7:0] d);
      return {d[6:0], 1'h0};
   endfunction : byp_exp
   task automatic chk(input string nm, input logic [108:0] seen, input logic [108:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 100);
      if (n >= 100) mismatches++;
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic sc(input logic ir, input int n, input logic [108:0] d);
      @(posedge pclk);
      ctl.scan(ir, n, d, dout);
   endtask : sc
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   initial begin
      #100000;
      mismatches++;
      print_verdict();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      repeat (4) @(posedge pclk);
      apb(1'h0, `SBT_OFF_STATUS, 32'h0);
      chk("reset status", rd[6:0], {3'h1, 4'hf});
      apb(1'h0, 12'h010, 32'h0);
      chk("unmapped", {err, rd}, {1'h1, 32'h0});
      apb(1'h1, `SBT_OFF_CTRL, 32'h1);
      @(posedge pclk);
      ctl.reset5();
      for (i = 0; i < 6; i++) begin
         din = 109'({$random(seed), $random(seed), $random(seed), $random(seed)});
         sc(1'h0, 96, din);
         if (i == 0) chk("idcode", dout[31:0], id_exp());
         for (int k = 0; k < 3; k++) q.push_back(din[k*32 +: 32]);
      end
      apb(1'h0, `SBT_OFF_STATUS, 32'h0);
      chk("full status", rd[10:8], 3'h7);
      for (i = 0; i < 17; i++) begin
         apb(1'h0, `SBT_OFF_DATA, 32'h0);
         chk("fifo word", rd, q[i]);
      end
      apb(1'h0, `SBT_OFF_DATA, 32'h0);
      chk("empty read", rd, 32'h0);
      apb(1'h1, `SBT_OFF_DATA, 32'h0);
      chk("data write", err, 1'h1);
      apb(1'h1, `SBT_OFF_STATUS, 32'h200);
      apb(1'h0, `SBT_OFF_STATUS, 32'h0);
      chk("cleared status", rd[10:8], 3'h0);
      apb(1'h1, `SBT_OFF_CTRL, 32'h0);
      for (i = 3; i < 8; i++) begin
         sc(1'h1, 3, 109'(i));
         chk("ir capture", dout[2:0], 3'h1);
         apb(1'h0, `SBT_OFF_STATUS, 32'h0);
         chk("instr", rd[6:0], {3'(i), 4'hc});
         din = 109'($random(seed));
         sc(1'h0, 8, din);
         chk("bypass", dout[7:0], byp_exp(din[7:0]));
      end
      for (i = 0; i < 3; i += 2) begin
         @(posedge pclk);
         io_ring <= sbt_ring_type'(109'({$random(seed), $random(seed), $random(seed), $random(seed)}));
         sc(1'h1, 3, 109'(i));
         din = 109'({$random(seed), $random(seed), $random(seed), $random(seed)});
         sc(1'h0, 109, din);
         chk("ring", dout, io_ring);
         chk("ring first", dout[0], io_ring.termination_control_input);
         chk("ring second", dout[1], io_ring.read_data_valid_output);
         apb(1'h0, `SBT_OFF_STATUS, 32'h0);
         chk("instr kept", rd[6:4], 3'(i));
      end
      @(posedge pclk);
      ctl.enter(1'h0);
      @(posedge pclk);
      ctl.reset5();
      apb(1'h0, `SBT_OFF_STATUS, 32'h0);
      chk("mid shift reset", rd[6:0], {3'h1, 4'hc});
      print_verdict();
   end
endmodule : sbt_tap_tb
